/* File: design/led_ind_defs.vh */
// Function
// - green supply indicator lit whenever supply present
// - alarm holds red steadily on, yellow
// - fault or no firmware: green only
// - no USB link: red blinks 0.25 Hz
// - connected and stopped: red blinks 1 Hz
// - moving: red blinks 4 Hz
// - reprogramming firmware: red blinks 8 Hz
// - USB reconnecting: red blinks 10 Hz
// - limit outputs high while switch active
// - copy power and status to connector
// - suspicious value enters alarm, blocks motion
// - alarm flag readable in status
// - leave alarm: values good plus stop
// - sticky option latches error flags
`ifndef LED_IND_DEFS_VH
`define LED_IND_DEFS_VH
`define CLK_HZ 250000000
// blink frequencies in millihertz
`define F_NOUSB_MHZ 250
`define F_STOP_MHZ 1000
`define F_MOVE_MHZ 4000
`define F_FLASH_MHZ 8000
`define F_RECON_MHZ 10000
// register byte offsets
`define A_CTRL 8'h00
`define A_STAT 8'h04
`define A_IRQ 8'h08
`define A_MASK 8'h0C
`define A_ERR 8'h10
// control bits
`define C_STICKY 0
`define C_POL_L 1
`define C_POL_R 2
`define C_STOP 3
`define CTRL_RST 4'h0
// interrupt events
`define E_ALARM 0
`define E_CLEAR 1
`define NEV 2
`define RESP_OK 2'h0
`define RESP_SLVERR 2'h2
`endif

/* File: design/blink_gen.v */
`timescale 1ns/1ps
// square wave with equal halves, period chosen by a half count
module blink_gen #(
  parameter W = 32
) (
  input wire clk,
  input wire rst_n,
  input wire [W-1:0] half_cnt,
  input wire restart,
  output reg blink
);
  reg [W-1:0] cnt_q;
  // restart keeps a new pattern from starting mid-phase
  always @(posedge clk)
  begin
    if (!rst_n || restart)
    begin
      cnt_q <= {W{1'b0}};
      blink <= 1'b1;
    end
    else if (cnt_q >= half_cnt - {{(W-1){1'b0}}, 1'b1})
    begin
      cnt_q <= {W{1'b0}};
      blink <= ~blink;
    end
    else
      cnt_q <= cnt_q + {{(W-1){1'b0}}, 1'b1};
  end
endmodule // blink_gen

/* File: design/led_mode_ind.v */
`timescale 1ns/1ps
`include "led_ind_defs.vh"
module led_mode_ind #(
  parameter NFLT = 4,
  parameter CLK_HZ = `CLK_HZ
) (
  input wire CLK,
  input wire RST_N,
  // mode inputs from the controller
  input wire SUPPLY_OK,
  input wire FW_FAULT,
  input wire REFLASH,
  input wire USB_RECONNECT,
  input wire USB_CONNECTED,
  input wire MOVING,
  input wire [NFLT-1:0] FAULT_IN,
  input wire LIMIT_L_IN,
  input wire LIMIT_R_IN,
  output wire MOTION_BLOCK,
  output reg LED_POWER,
  output reg LED_STATUS,
  output reg CONN_POWER,
  output reg CONN_STATUS,
  output reg CONN_LIMIT_L,
  output reg CONN_LIMIT_R,
  output wire IRQ,
  // axi4-lite slave
  input wire [7:0] S_AWADDR,
  input wire S_AWVALID,
  output wire S_AWREADY,
  input wire [31:0] S_WDATA,
  input wire [3:0] S_WSTRB,
  input wire S_WVALID,
  output wire S_WREADY,
  output reg [1:0] S_BRESP,
  output reg S_BVALID,
  input wire S_BREADY,
  input wire [7:0] S_ARADDR,
  input wire S_ARVALID,
  output wire S_ARREADY,
  output reg [31:0] S_RDATA,
  output reg [1:0] S_RRESP,
  output reg S_RVALID,
  input wire S_RREADY
);
  ////////////////////////////////////////////////////////////////////////
  // half periods in cycles: clk*1000/(2*f_mHz)
  // kept at 64 bits since clock times a thousand overflows 32 bits
  localparam [63:0] CK = CLK_HZ * 64'd1;
  localparam [63:0] H_NOUSB = (CK * 64'd1000) / (64'd2 * `F_NOUSB_MHZ);
  localparam [63:0] H_STOP = (CK * 64'd1000) / (64'd2 * `F_STOP_MHZ);
  localparam [63:0] H_MOVE = (CK * 64'd1000) / (64'd2 * `F_MOVE_MHZ);
  localparam [63:0] H_FLASH = (CK * 64'd1000) / (64'd2 * `F_FLASH_MHZ);
  localparam [63:0] H_RECON = (CK * 64'd1000) / (64'd2 * `F_RECON_MHZ);
  // one-hot indication modes
  localparam [7:0] M_OFF = 8'h01;
  localparam [7:0] M_ALARM = 8'h02;
  localparam [7:0] M_FW = 8'h04;
  localparam [7:0] M_FLASH = 8'h08;
  localparam [7:0] M_RECON = 8'h10;
  localparam [7:0] M_NOUSB = 8'h20;
  localparam [7:0] M_MOVE = 8'h40;
  localparam [7:0] M_STOP = 8'h80;

  ////////////////////////////////////////////////////////////////////////
  reg [3:0] ctrl_q;
  reg [NFLT-1:0] err_q;
  reg alarm_q;
  reg [`NEV-1:0] irq_q;
  reg [`NEV-1:0] mask_q;
  reg [7:0] mode_q;
  reg [7:0] mode_d;
  reg [31:0] half_sel;
  wire blink;
  wire any_fault = |FAULT_IN;
  wire stop_cmd;
  wire alarm_set;
  wire alarm_clr;

  ////////////////////////////////////////////////////////////////////////
  // register map, one word each:
  //   CTRL  [0] sticky errors, [1]/[2] left/right limit inverted,
  //         [3] stop command, self-clearing, reads back as zero
  //   STAT  read-only indication state, writes ignored
  //   IRQ   write-one-to-clear events, MASK enables them onto IRQ
  //   ERR   read-only fault flags, live or latched per sticky bit
  // bus handshake: one write and one read outstanding
  wire wr_go = S_AWVALID && S_WVALID && !S_BVALID;
  wire rd_go = S_ARVALID && !S_RVALID;
  assign S_AWREADY = wr_go;
  assign S_WREADY = wr_go;
  assign S_ARREADY = rd_go;
  // only byte lane 0 carries register bits; other lanes are ignored
  wire wr_ctrl = wr_go && (S_AWADDR == `A_CTRL) && S_WSTRB[0];
  wire wr_irq = wr_go && (S_AWADDR == `A_IRQ) && S_WSTRB[0];
  wire wr_mask = wr_go && (S_AWADDR == `A_MASK) && S_WSTRB[0];
  wire wr_ok = (S_AWADDR == `A_CTRL) || (S_AWADDR == `A_IRQ) ||
               (S_AWADDR == `A_MASK) || (S_AWADDR == `A_STAT) ||
               (S_AWADDR == `A_ERR);
  // stop is a self-clearing command bit
  assign stop_cmd = wr_ctrl && S_WDATA[`C_STOP];

  // write response
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      S_BVALID <= 1'b0;
      S_BRESP <= `RESP_OK;
    end
    else if (wr_go)
    begin
      S_BVALID <= 1'b1;
      S_BRESP <= wr_ok ? `RESP_OK : `RESP_SLVERR;
    end
    else if (S_BREADY)
      S_BVALID <= 1'b0;
  end

  // register writes; status and error words are read-only
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      ctrl_q <= `CTRL_RST;
      mask_q <= {`NEV{1'b0}};
    end
    else
    begin
      if (wr_ctrl)
        ctrl_q <= {1'b0, S_WDATA[2:0]};
      if (wr_mask)
        mask_q <= S_WDATA[`NEV-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alarm: entered on any fault, left on stop with faults gone
  assign alarm_set = any_fault;
  // a stop sent while a fault is still present is ignored on purpose
  assign alarm_clr = stop_cmd && !any_fault;
  always @(posedge CLK)
  begin
    if (!RST_N)
      alarm_q <= 1'b0;
    else if (alarm_set)
      alarm_q <= 1'b1;
    else if (alarm_clr)
      alarm_q <= 1'b0;
  end
  // motion refused while alarm holds, even the fault cycle itself
  assign MOTION_BLOCK = alarm_q || any_fault;

  // error flags: latched until stop when sticky, else live
  always @(posedge CLK)
  begin
    if (!RST_N)
      err_q <= {NFLT{1'b0}};
    else if (ctrl_q[`C_STICKY])
      err_q <= (stop_cmd ? {NFLT{1'b0}} : err_q) | FAULT_IN;
    else
      err_q <= FAULT_IN;
  end

  // sticky events, set wins over write-one clear
  // so an event landing with a clear write is never lost
  wire [`NEV-1:0] ev;
  assign ev[`E_ALARM] = alarm_set && !alarm_q;
  assign ev[`E_CLEAR] = alarm_clr && alarm_q;
  always @(posedge CLK)
  begin
    if (!RST_N)
      irq_q <= {`NEV{1'b0}};
    else
      irq_q <= (irq_q & ~(wr_irq ? S_WDATA[`NEV-1:0] : {`NEV{1'b0}})) | ev;
  end
  assign IRQ = |(irq_q & mask_q);

  ////////////////////////////////////////////////////////////////////////
  // status word: [0] alarm, [8:1] one-hot mode, [10:9] raw limits
  wire [31:0] stat_word;
  assign stat_word = {21'h000000, LIMIT_R_IN, LIMIT_L_IN, mode_q,
                      alarm_q};
  // read data path
  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      S_RVALID <= 1'b0;
      S_RDATA <= 32'h00000000;
      S_RRESP <= `RESP_OK;
    end
    else if (rd_go)
    begin
      S_RVALID <= 1'b1;
      S_RRESP <= `RESP_OK;
      case (S_ARADDR)
        `A_CTRL: S_RDATA <= {28'h0000000, ctrl_q};
        `A_STAT: S_RDATA <= stat_word;
        `A_IRQ: S_RDATA <= {{(32-`NEV){1'b0}}, irq_q};
        `A_MASK: S_RDATA <= {{(32-`NEV){1'b0}}, mask_q};
        `A_ERR: S_RDATA <= {{(32-NFLT){1'b0}}, err_q};
        default:
        begin
          S_RDATA <= 32'h00000000;
          S_RRESP <= `RESP_SLVERR;
        end
      endcase
    end
    else if (S_RREADY)
      S_RVALID <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // mode selection by fixed priority
  always @*
  begin
    mode_d = M_STOP;
    if (!SUPPLY_OK)
      mode_d = M_OFF;
    else if (alarm_q)
      mode_d = M_ALARM;
    else if (FW_FAULT)
      mode_d = M_FW;
    else if (REFLASH)
      mode_d = M_FLASH;
    else if (USB_RECONNECT)
      mode_d = M_RECON;
    else if (!USB_CONNECTED)
      mode_d = M_NOUSB;
    else if (MOVING)
      mode_d = M_MOVE;
  end

  always @(posedge CLK)
  begin
    if (!RST_N)
      mode_q <= M_OFF;
    else
      mode_q <= mode_d;
  end

  // blink rate per mode; the slowest half fits 32 bits at any
  // sensible clock, so the upper half of each figure is dropped
  always @*
  begin
    case (mode_q)
      M_NOUSB: half_sel = H_NOUSB[31:0];
      M_MOVE: half_sel = H_MOVE[31:0];
      M_FLASH: half_sel = H_FLASH[31:0];
      M_RECON: half_sel = H_RECON[31:0];
      default: half_sel = H_STOP[31:0];
    endcase
  end

  // one shared divider: only one pattern is ever shown at a time

  blink_gen #(
    .W(32)
  ) u_blink (
    .clk(CLK),
    .rst_n(RST_N),
    .half_cnt(half_sel),
    .restart(mode_d != mode_q),
    .blink(blink)
  );

  ////////////////////////////////////////////////////////////////////////
  // indicator and connector outputs, registered
  reg status_d;
  always @*
  begin
    case (mode_q)
      M_OFF: status_d = 1'b0;
      M_ALARM: status_d = 1'b1;
      M_FW: status_d = 1'b0;
      default: status_d = blink;
    endcase
  end

  always @(posedge CLK)
  begin
    if (!RST_N)
    begin
      LED_POWER <= 1'b0;
      LED_STATUS <= 1'b0;
      CONN_POWER <= 1'b0;
      CONN_STATUS <= 1'b0;
      CONN_LIMIT_L <= 1'b0;
      CONN_LIMIT_R <= 1'b0;
    end
    else
    begin
      LED_POWER <= SUPPLY_OK;
      LED_STATUS <= status_d;
      CONN_POWER <= SUPPLY_OK;
      CONN_STATUS <= status_d;
      // polarity bit set means switch active low
      CONN_LIMIT_L <= LIMIT_L_IN ^ ctrl_q[`C_POL_L];
      CONN_LIMIT_R <= LIMIT_R_IN ^ ctrl_q[`C_POL_R];
    end
  end
endmodule // led_mode_ind

/* File: testbench/led_watch.sv */
`timescale 1ns/1ps
// far-side indicator pin: measures the length of the last lit/dark span
module led_watch (
  input wire clk,
  input wire s,
  output reg [31:0] half
);
  reg [31:0] cnt_q = 32'h0;
  reg s_q = 1'b0;
  // span counter; a pin that never toggles keeps the old figure
  always @(posedge clk)
  begin
    s_q <= s;
    cnt_q <= (s != s_q) ? 32'h1 : cnt_q + 32'h1;
    if (s != s_q)
      half <= cnt_q;
  end
endmodule // led_watch

/* File: testbench/led_mode_ind_assertions.sv */
`timescale 1ns/1ps
module led_mode_ind_chk #(
  parameter NFLT = 4
) (
  input logic CLK,
  input logic RST_N,
  input logic SUPPLY_OK,
  input logic FW_FAULT,
  input logic [NFLT-1:0] FAULT_IN,
  input logic LIMIT_L_IN,
  input logic MOTION_BLOCK,
  input logic LED_POWER,
  input logic LED_STATUS,
  input logic CONN_POWER,
  input logic CONN_STATUS,
  input logic CONN_LIMIT_L,
  input logic S_AWVALID,
  input logic S_WVALID,
  input logic S_AWREADY,
  input logic S_BVALID
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////////////////////////////////////
  // indicator outputs
  property p_pwr; SUPPLY_OK |=> LED_POWER; endproperty
  a_pwr: assert property (p_pwr) else $error("power led off");
  property p_dark; !SUPPLY_OK [*3] |=> !LED_STATUS; endproperty
  a_dark: assert property (p_dark) else $error("status lit");
  property p_cp; CONN_POWER == LED_POWER; endproperty
  a_cp: assert property (p_cp) else $error("power pin differs");
  property p_cs; CONN_STATUS == LED_STATUS; endproperty
  a_cs: assert property (p_cs) else $error("status pin differs");
  // alarm path: flag, mode and led register make three stages
  property p_blk; |FAULT_IN |-> MOTION_BLOCK; endproperty
  a_blk: assert property (p_blk) else $error("motion not blocked");
  property p_alarm; (|FAULT_IN && SUPPLY_OK) [*3] |=> LED_STATUS;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm not red");
  property p_fw; (FW_FAULT && !MOTION_BLOCK && SUPPLY_OK) [*4]
    |=> !LED_STATUS; endproperty
  a_fw: assert property (p_fw) else $error("red lit on fault");
  // limit pin follows input unless polarity was just rewritten
  property p_lim; $past(RST_N) && $changed(LIMIT_L_IN) && !$past(S_WVALID)
    |=> $changed(CONN_LIMIT_L); endproperty
  a_lim: assert property (p_lim) else $error("limit pin stuck");
  property p_b; S_AWVALID && S_WVALID && S_AWREADY |=> S_BVALID;
  endproperty
  a_b: assert property (p_b) else $error("no write response");
endmodule // led_mode_ind_chk
bind led_mode_ind led_mode_ind_chk #(.NFLT(NFLT)) chk_inst (
  .CLK(CLK),
  .RST_N(RST_N),
  .SUPPLY_OK(SUPPLY_OK),
  .FW_FAULT(FW_FAULT),
  .FAULT_IN(FAULT_IN),
  .LIMIT_L_IN(LIMIT_L_IN),
  .MOTION_BLOCK(MOTION_BLOCK),
  .LED_POWER(LED_POWER),
  .LED_STATUS(LED_STATUS),
  .CONN_POWER(CONN_POWER),
  .CONN_STATUS(CONN_STATUS),
  .CONN_LIMIT_L(CONN_LIMIT_L),
  .S_AWVALID(S_AWVALID),
  .S_WVALID(S_WVALID),
  .S_AWREADY(S_AWREADY),
  .S_BVALID(S_BVALID)
);

/* File: testbench/tb_led_mode_ind.sv */
`timescale 1ns/1ps
module tb_led_mode_ind;
  reg CLK=0,RST_N=0,SUPPLY_OK=1,FW_FAULT=0,REFLASH=0,USB_RECONNECT=0;
  reg USB_CONNECTED=0,MOVING=0,LIMIT_L_IN=0,LIMIT_R_IN=0,S_BREADY=1;
  reg S_AWVALID=0,S_WVALID=0,S_ARVALID=0,S_RREADY=1;
  reg [3:0] FAULT_IN=4'h0,S_WSTRB=4'hF;
  reg [7:0] S_AWADDR=8'h00,S_ARADDR=8'h00;
  reg [31:0] S_WDATA=32'h0,seed=32'h77F8,d,h;
  reg [1:0] rsp;
  wire MOTION_BLOCK,LED_POWER,LED_STATUS,CONN_POWER,CONN_STATUS,IRQ;
  wire CONN_LIMIT_L,CONN_LIMIT_R,S_AWREADY,S_WREADY,S_BVALID;
  wire S_ARREADY,S_RVALID;
  wire [1:0] S_BRESP,S_RRESP;
  wire [31:0] S_RDATA,half;
  integer mismatches=0,n_tests=0,i;
  integer fm[0:4]='{250,1000,4000,8000,10000};
  // shortened clock rate keeps blink halves between 50 and 2000 cycles
  led_mode_ind #(.CLK_HZ(1000)) led_mode_ind_inst (
    .CLK(CLK),
    .RST_N(RST_N),
    .SUPPLY_OK(SUPPLY_OK),
    .FW_FAULT(FW_FAULT),
    .REFLASH(REFLASH),
    .USB_RECONNECT(USB_RECONNECT),
    .USB_CONNECTED(USB_CONNECTED),
    .MOVING(MOVING),
    .FAULT_IN(FAULT_IN),
    .LIMIT_L_IN(LIMIT_L_IN),
    .LIMIT_R_IN(LIMIT_R_IN),
    .MOTION_BLOCK(MOTION_BLOCK),
    .LED_POWER(LED_POWER),
    .LED_STATUS(LED_STATUS),
    .CONN_POWER(CONN_POWER),
    .CONN_STATUS(CONN_STATUS),
    .CONN_LIMIT_L(CONN_LIMIT_L),
    .CONN_LIMIT_R(CONN_LIMIT_R),
    .IRQ(IRQ),
    .S_AWADDR(S_AWADDR),
    .S_AWVALID(S_AWVALID),
    .S_AWREADY(S_AWREADY),
    .S_WDATA(S_WDATA),
    .S_WSTRB(S_WSTRB),
    .S_WVALID(S_WVALID),
    .S_WREADY(S_WREADY),
    .S_BRESP(S_BRESP),
    .S_BVALID(S_BVALID),
    .S_BREADY(S_BREADY),
    .S_ARADDR(S_ARADDR),
    .S_ARVALID(S_ARVALID),
    .S_ARREADY(S_ARREADY),
    .S_RDATA(S_RDATA),
    .S_RRESP(S_RRESP),
    .S_RVALID(S_RVALID),
    .S_RREADY(S_RREADY)
  );
  led_watch led_watch_inst (.clk(CLK), .s(CONN_STATUS), .half(half));
  initial
  begin
    forever #2 CLK = ~CLK;
  end
  ////////////////////////////////////////////////////////////////////////
  function [31:0] xs(input [31:0] x);
  begin
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    xs = x ^ (x << 5);
  end
  endfunction
  task w(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task chk(input [39:0] nm, input [31:0] e, input [31:0] s);
  begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      $display("ERROR %0s exp %h got %h", nm, e, s);
      mismatches = mismatches + 1;
    end
  end
  endtask
  // ready is judged mid-cycle, so the taking edge is never raced
  task wr(input [7:0] a, input [31:0] v);
  begin
    @(posedge CLK);
    S_AWADDR <= a;
    S_WDATA <= v;
    S_AWVALID <= 1;
    S_WVALID <= 1;
    @(negedge CLK);
    while (!(S_AWREADY && S_WREADY)) @(negedge CLK);
    @(posedge CLK);
    S_AWVALID <= 0;
    S_WVALID <= 0;
    while (!S_BVALID) @(negedge CLK);
    rsp = S_BRESP;
    @(posedge CLK);
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge CLK);
    S_ARADDR <= a;
    S_ARVALID <= 1;
    @(negedge CLK);
    while (!S_ARREADY) @(negedge CLK);
    @(posedge CLK);
    S_ARVALID <= 0;
    while (!S_RVALID) @(negedge CLK);
    d = S_RDATA;
    rsp = S_RRESP;
    @(posedge CLK);
  end
  endtask
  task finish_test;
  begin
    if (mismatches == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog, well past the longest blink wait
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    finish_test;
  end
  // main sequence
  initial
  begin
    repeat (2) @(posedge CLK);
    RST_N <= 1;
    @(posedge CLK);
    FW_FAULT <= 1;
    USB_CONNECTED <= 1;
    w(4);
    chk("fw", 0, LED_STATUS);
    chk("pwr", 1, LED_POWER);
    @(posedge CLK);
    FW_FAULT <= 0;
    for (i = 0; i < 5; i = i + 1)
    begin
      h = 32'h48320 >> (4 * i);
      @(posedge CLK);
      {REFLASH,USB_RECONNECT,USB_CONNECTED,MOVING} <= h[3:0];
      h = 1000000 / (2 * fm[i]);
      w(3 * h + 20);
      chk("half", h, half);
    end
    for (i = 0; i < 8; i = i + 1)
    begin
      seed = xs(seed);
      wr(8'h00, {29'h0, seed[2:1], 1'b0});
      @(posedge CLK);
      LIMIT_L_IN <= seed[3];
      LIMIT_R_IN <= seed[4];
      w(2);
      chk("liml", seed[3] ^ seed[1], CONN_LIMIT_L);
      chk("limr", seed[4] ^ seed[2], CONN_LIMIT_R);
    end
    rd(8'h00);
    chk("ctrl", {29'h0, seed[2:1], 1'b0}, d);
    rd(8'h40);
    chk("resp", 2, rsp);
    wr(8'h40, 32'h0000000F);
    chk("bresp", 2, rsp);
    // alarm entered with sticky errors, then cleared by stop
    wr(8'h00, 1);
    wr(8'h0C, 1);
    h = seed[3:0] | 4'h1;
    @(posedge CLK);
    FAULT_IN <= h[3:0];
    w(5);
    chk("red", 1, LED_STATUS);
    chk("blk", 1, MOTION_BLOCK);
    chk("irq", 1, IRQ);
    wr(8'h0C, 0);
    chk("irqm", 0, IRQ);
    wr(8'h00, 9);
    @(posedge CLK);
    FAULT_IN <= 4'h0;
    w(3);
    chk("hold", 1, MOTION_BLOCK);
    rd(8'h10);
    chk("err", h, d);
    rd(8'h04);
    chk("alm", 1, d[0]);
    wr(8'h00, 8);
    rd(8'h04);
    chk("alm", 0, d[0]);
    rd(8'h10);
    chk("err", 0, d);
    rd(8'h08);
    chk("ist", 3, d);
    wr(8'h08, 3);
    chk("bok", 0, rsp);
    rd(8'h08);
    chk("ist", 0, d);
    @(posedge CLK);
    SUPPLY_OK <= 0;
    w(6);
    chk("dark", 0, {LED_POWER,LED_STATUS,CONN_POWER,CONN_STATUS});
    finish_test;
  end
endmodule // tb_led_mode_ind
